// [logic/css_pkg.sv]
// Constants, types and the register map of the clock source select block.
// Assumes one register clock, an active-low asynchronous reset and a plain register port.
package css_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [31:0] SYS_PLL_INPUT_SELECT_ADDR = 32'h4004_8040;
    localparam logic [31:0] SYS_PLL_INPUT_UPDATE_ADDR = 32'h4004_8044;
    localparam logic [31:0] USB_PLL_INPUT_SELECT_ADDR = 32'h4004_8048;
    localparam logic [31:0] USB_PLL_UPDATE_REG_ADDR = 32'h4004_804C;
    localparam logic [31:0] MAIN_CLOCK_SELECT_ADDR = 32'h4004_8070;
    localparam logic [31:0] MAIN_CLOCK_UPDATE_ADDR = 32'h4004_8074;
    localparam logic [31:0] USB_ROUTE_ENABLE_ADDR = 32'h4004_80C0;
    localparam logic [31:0] MUX_STATUS_ADDR = 32'h4004_80C4;

    // Index 0 system PLL input, 1 USB PLL input, 2 main clock
    localparam int NUM_MUX = 3;
    localparam logic [2:0][31:0] SEL_ADDR = {MAIN_CLOCK_SELECT_ADDR, USB_PLL_INPUT_SELECT_ADDR,
                                             SYS_PLL_INPUT_SELECT_ADDR};
    localparam logic [2:0][31:0] UPD_ADDR = {MAIN_CLOCK_UPDATE_ADDR, USB_PLL_UPDATE_REG_ADDR,
                                             SYS_PLL_INPUT_UPDATE_ADDR};

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int SEL_W = 2;
    localparam int GATE_W = 4;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic UPD_RESET = 1'b0;
    localparam logic ROUTE_RESET = 1'b0;
    localparam logic [31:0] SEL_MASK = 32'h0000_0003;
    localparam logic [31:0] BIT0_MASK = 32'h0000_0001;
    // Source codes
    localparam logic [1:0] SRC_IRC = 2'h0;
    localparam logic [1:0] SRC_SYSOSC = 2'h1;
    localparam logic [1:0] SRC_MAIN_WDT = 2'h2;
    localparam logic [1:0] SRC_MAIN_PLLOUT = 2'h3;
    // Status word fields
    localparam int STAT_BUSY_LSB = 6;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int HANDOVER_GAP_NS = 300;
    localparam int GAP_CYCLES = (HANDOVER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MUX_RUN = 2'b01,
        MUX_GAP = 2'b10
    } css_state_t;

    typedef enum logic [1:0] {
        KIND_SEL = 2'h0,
        KIND_UPD = 2'h1,
        KIND_ROUTE = 2'h2,
        KIND_STAT = 2'h3
    } css_kind_t;

    typedef struct packed {
        css_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [SEL_W-1:0] target;
        logic [SEL_W-1:0] active;
        logic [GATE_W-1:0] gate;
    } css_mux_t;

    typedef struct packed {
        logic hit;
        css_kind_t kind;
        logic [1:0] mux;
    } css_dec_t;

    localparam css_mux_t MUX_RESET = '{state: MUX_RUN, cnt: 2'h0, target: SEL_RESET,
                                       active: SEL_RESET, gate: 4'h1};

endpackage

// [logic/css_top.sv]
// Clock source select block: three select/update register pairs and three handover engines.
// Assumes external glitch-free gating cells driven by the one-hot gate outputs, and
// that software keeps both old and new clocks running while a handover is in progress.
module css_top (
    input wire logic clk, // Register clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [31:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, valid the cycle after rd
    output logic [1:0] sysPllSrc, // Active system PLL input code
    output logic [3:0] sysPllGate, // One-hot gate enables, system PLL input
    output logic [1:0] usbPllSrc, // Active USB PLL input code
    output logic [3:0] usbPllGate, // One-hot gate enables, USB PLL input
    output logic [1:0] mainSrc, // Active main clock code
    output logic [3:0] mainGate, // One-hot gate enables, main clock to core
    output logic mainUsbRoute // Main clock also routed to USB block
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic css_pkg::css_dec_t decode(input logic [31:0] a);
        css_pkg::css_dec_t d;
        d = '0;
        for (int i = 0; i < css_pkg::NUM_MUX; i++) begin
            if (a == css_pkg::SEL_ADDR[i]) begin
                d = '{hit: 1'b1, kind: css_pkg::KIND_SEL, mux: 2'(i)};
            end
            if (a == css_pkg::UPD_ADDR[i]) begin
                d = '{hit: 1'b1, kind: css_pkg::KIND_UPD, mux: 2'(i)};
            end
        end
        if (a == css_pkg::USB_ROUTE_ENABLE_ADDR) begin
            d = '{hit: 1'b1, kind: css_pkg::KIND_ROUTE, mux: 2'h0};
        end
        if (a == css_pkg::MUX_STATUS_ADDR) begin
            d = '{hit: 1'b1, kind: css_pkg::KIND_STAT, mux: 2'h0};
        end
        return d;
    endfunction

    function automatic logic [3:0] onehot(input logic [1:0] s);
        return 4'h1 << s;
    endfunction

    css_pkg::css_dec_t dec;
    logic [2:0][1:0] selReg_r, selReg_nxt;
    logic [2:0] updReg_r, updReg_nxt;
    logic routeReg_r, routeReg_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [2:0] updRise;
    logic [2:0] busy;
    css_pkg::css_mux_t mux_r [3];
    css_pkg::css_mux_t mux_nxt [3];

    // Gap counter load value: the engine counts this down to zero before the new gate rises
    localparam logic [css_pkg::CNT_W-1:0] CNT_W_GAP = css_pkg::CNT_W'(css_pkg::GAP_CYCLES - 1);

    assign dec = decode(addr);

    // ************************************************************
    // Register file
    // ************************************************************
    always_comb begin
        selReg_nxt = selReg_r;
        updReg_nxt = updReg_r;
        routeReg_nxt = routeReg_r;
        rdata_nxt = 32'h0;
        if (wr && dec.hit) begin
            unique case (dec.kind)
                css_pkg::KIND_SEL: selReg_nxt[dec.mux] = wdata[1:0];
                css_pkg::KIND_UPD: updReg_nxt[dec.mux] = wdata[0];
                css_pkg::KIND_ROUTE: routeReg_nxt = wdata[0];
                css_pkg::KIND_STAT: routeReg_nxt = routeReg_r;
            endcase
        end
        // Reads outside the map and the idle cycles return zero
        if (rd && dec.hit) begin
            unique case (dec.kind)
                css_pkg::KIND_SEL: rdata_nxt = {30'h0, selReg_r[dec.mux]};
                css_pkg::KIND_UPD: rdata_nxt = {31'h0, updReg_r[dec.mux]};
                css_pkg::KIND_ROUTE: rdata_nxt = {31'h0, routeReg_r};
                css_pkg::KIND_STAT: rdata_nxt = {23'h0, busy, mux_r[2].active,
                                                 mux_r[1].active, mux_r[0].active};
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            selReg_r <= {3{css_pkg::SEL_RESET}};
            updReg_r <= {3{css_pkg::UPD_RESET}};
            routeReg_r <= css_pkg::ROUTE_RESET;
            rdata_r <= 32'h0;
        end else begin
            selReg_r <= selReg_nxt;
            updReg_r <= updReg_nxt;
            routeReg_r <= routeReg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    rd_idle_zero_a: assert property (!rd |=> rdata_r == 32'h0)
        else $error("read data not zero outside a read reply");
    route_write_a: assert property ((wr && dec.hit && dec.kind == css_pkg::KIND_ROUTE)
        |=> {31'h0, mainUsbRoute} == ($past(wdata) & css_pkg::BIT0_MASK))
        else $error("USB route enable did not follow the write");

    // ************************************************************
    // Register port checks
    // ************************************************************
    // Only a mapped write may move a register; reads and stray writes must not
    unmapped_read_a: assert property ((rd && !dec.hit)
        |=> rdata_r == 32'h0)
        else $error("unmapped read returned nonzero data");

    unmapped_write_a: assert property ((wr && !dec.hit)
        |=> $stable(selReg_r) && $stable(updReg_r) && $stable(routeReg_r))
        else $error("unmapped write changed a register");

    idle_hold_a: assert property (!wr
        |=> $stable(selReg_r) && $stable(updReg_r) && $stable(routeReg_r))
        else $error("register changed without a write");

    status_write_a: assert property ((wr && dec.hit && dec.kind == css_pkg::KIND_STAT)
        |=> $stable(selReg_r) && $stable(updReg_r) && $stable(routeReg_r))
        else $error("write to the status word changed a register");

    route_hold_a: assert property (!(wr && dec.hit && dec.kind == css_pkg::KIND_ROUTE)
        |=> $stable(mainUsbRoute))
        else $error("USB route enable moved without a write");

    route_readback_a: assert property ((rd && dec.hit && dec.kind == css_pkg::KIND_ROUTE)
        |=> rdata_r == {31'h0, $past(mainUsbRoute)})
        else $error("USB route enable read back wrong");

    // The status word is the only view software has of a handover in flight
    status_readback_a: assert property ((rd && dec.hit && dec.kind == css_pkg::KIND_STAT)
        |=> rdata_r[31:9] == 23'h0 && rdata_r[5:4] == $past(mainSrc)
        && rdata_r[3:2] == $past(usbPllSrc) && rdata_r[1:0] == $past(sysPllSrc))
        else $error("status word wrong or with reserved bits set");

    // ************************************************************
    // Handover engines
    // ************************************************************
    // The gate of the old source drops first and the new one rises only after a
    // dead gap, so no runt pulse can reach the clock tree. The cost is a few cycles
    // with no clock out of the mux; reserved codes still gate, and stop that clock.
    for (genvar g = 0; g < css_pkg::NUM_MUX; g++) begin : g_mux
        assign updRise[g] = updReg_nxt[g] & ~updReg_r[g];
        assign busy[g] = (mux_r[g].state == css_pkg::MUX_GAP);

        always_comb begin
            mux_nxt[g] = mux_r[g];
            unique case (mux_r[g].state)
                css_pkg::MUX_RUN: begin
                    if (updRise[g] && selReg_r[g] != mux_r[g].active) begin
                        mux_nxt[g].target = selReg_r[g];
                        mux_nxt[g].gate = 4'h0;
                        mux_nxt[g].cnt = CNT_W_GAP;
                        mux_nxt[g].state = css_pkg::MUX_GAP;
                    end
                end
                css_pkg::MUX_GAP: begin
                    // A second edge during the gap retargets without a new gap
                    if (updRise[g]) begin
                        mux_nxt[g].target = selReg_r[g];
                    end
                    if (mux_r[g].cnt == 2'h0) begin
                        mux_nxt[g].active = mux_nxt[g].target;
                        mux_nxt[g].gate = onehot(mux_nxt[g].target);
                        mux_nxt[g].state = css_pkg::MUX_RUN;
                    end else begin
                        mux_nxt[g].cnt = mux_r[g].cnt - 2'h1;
                    end
                end
                default: mux_nxt[g] = css_pkg::MUX_RESET;
            endcase
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                mux_r[g] <= css_pkg::MUX_RESET;
            end else begin
                mux_r[g] <= mux_nxt[g];
            end
        end

        sel_write_a: assert property ((wr && dec.hit && dec.kind == css_pkg::KIND_SEL
            && dec.mux == 2'(g)) |=> {30'h0, selReg_r[g]} == ($past(wdata) & css_pkg::SEL_MASK))
            else $error("selector did not take the written code");
        upd_write_a: assert property ((wr && dec.hit && dec.kind == css_pkg::KIND_UPD
            && dec.mux == 2'(g)) |=> {31'h0, updReg_r[g]} == ($past(wdata) & css_pkg::BIT0_MASK))
            else $error("update bit did not take the written value");
        sel_readback_a: assert property ((rd && dec.hit && dec.kind == css_pkg::KIND_SEL
            && dec.mux == 2'(g)) |=> rdata_r == {30'h0, $past(selReg_r[g])})
            else $error("selector read back wrong or with reserved bits set");
        no_edge_hold_a: assert property ((mux_r[g].state == css_pkg::MUX_RUN && !updRise[g])
            |=> $stable(mux_r[g].active) && mux_r[g].state == css_pkg::MUX_RUN)
            else $error("source changed without an update edge");
        zero_write_a: assert property ((wr && dec.hit && dec.kind == css_pkg::KIND_UPD
            && dec.mux == 2'(g) && !wdata[0] && mux_r[g].state == css_pkg::MUX_RUN)
            |=> $stable(mux_r[g].active) && !busy[g])
            else $error("writing zero to update changed the source");
        handover_a: assert property ((mux_r[g].state == css_pkg::MUX_RUN && updRise[g]
            && selReg_r[g] != mux_r[g].active)
            |=> (mux_r[g].gate == 4'h0) [*3] ##1 (mux_r[g].gate == onehot(mux_r[g].active)
            && mux_r[g].active == $past(selReg_r[g], 4)))
            else $error("handover gap or new source wrong");
        gate_onehot_a: assert property ($onehot0(mux_r[g].gate))
            else $error("two sources gated on at once");
        gate_match_a: assert property (mux_r[g].state == css_pkg::MUX_RUN
            |-> mux_r[g].gate == onehot(mux_r[g].active))
            else $error("running gate does not match the active source");

        // Engine sequencing: entry, countdown, exit and the quiet cases
        // The edge is taken from the write itself, so a one held in the register never re-arms
        upd_rise_src_a: assert property (updRise[g]
            |-> wr && dec.hit && dec.kind == css_pkg::KIND_UPD && dec.mux == 2'(g) && wdata[0])
            else $error("update edge seen without a write of one");

        sel_hold_a: assert property (!(wr && dec.hit && dec.kind == css_pkg::KIND_SEL
            && dec.mux == 2'(g)) |=> $stable(selReg_r[g]))
            else $error("selector moved without a write");

        upd_hold_a: assert property (!(wr && dec.hit && dec.kind == css_pkg::KIND_UPD
            && dec.mux == 2'(g)) |=> $stable(updReg_r[g]))
            else $error("update bit moved without a write");

        upd_readback_a: assert property ((rd && dec.hit && dec.kind == css_pkg::KIND_UPD
            && dec.mux == 2'(g)) |=> rdata_r == {31'h0, $past(updReg_r[g])})
            else $error("update bit read back wrong or with reserved bits set");

        gap_entry_a: assert property ((mux_r[g].state == css_pkg::MUX_RUN && updRise[g]
            && selReg_r[g] != mux_r[g].active)
            |=> mux_r[g].state == css_pkg::MUX_GAP && mux_r[g].cnt == CNT_W_GAP
            && mux_r[g].target == $past(selReg_r[g]))
            else $error("handover did not start on the update edge");

        gap_step_a: assert property ((mux_r[g].state == css_pkg::MUX_GAP
            && mux_r[g].cnt != 2'h0)
            |=> mux_r[g].state == css_pkg::MUX_GAP
            && mux_r[g].cnt == $past(mux_r[g].cnt) - 2'h1)
            else $error("handover gap did not count down");

        // A late edge may retarget, so the exit check skips that cycle
        gap_end_a: assert property ((mux_r[g].state == css_pkg::MUX_GAP
            && mux_r[g].cnt == 2'h0 && !updRise[g])
            |=> mux_r[g].state == css_pkg::MUX_RUN
            && mux_r[g].active == $past(mux_r[g].target))
            else $error("handover did not end on the new source");

        gap_dark_a: assert property (mux_r[g].state == css_pkg::MUX_GAP
            |-> mux_r[g].gate == 4'h0)
            else $error("a source was gated on during the handover gap");

        retarget_a: assert property ((mux_r[g].state == css_pkg::MUX_GAP && updRise[g])
            |=> mux_r[g].target == $past(selReg_r[g]))
            else $error("second update edge did not retarget");

        same_code_a: assert property ((mux_r[g].state == css_pkg::MUX_RUN && updRise[g]
            && selReg_r[g] == mux_r[g].active)
            |=> mux_r[g].state == css_pkg::MUX_RUN && $stable(mux_r[g].active))
            else $error("update with the active code started a handover");

        run_gate_hold_a: assert property ((mux_r[g].state == css_pkg::MUX_RUN
            && !updRise[g]) |=> $stable(mux_r[g].gate))
            else $error("gate moved while the mux was running");
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata = rdata_r;
    assign sysPllSrc = mux_r[0].active;
    assign sysPllGate = mux_r[0].gate;
    assign usbPllSrc = mux_r[1].active;
    assign usbPllGate = mux_r[1].gate;
    assign mainSrc = mux_r[2].active;
    assign mainGate = mux_r[2].gate;
    assign mainUsbRoute = routeReg_r;

endmodule

// [sim/css_top_tb_top.sv]
// Self-checking bench for the clock source select block: register port, handover, reset.
// Assumes a 10 MHz register clock and the 3-cycle handover gap given in the package.
module css_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    `define CHK(nm, e, g) check(nm, 32'(e), 32'(g))

    logic clk, nrst, wr, rd;
    logic [31:0] addr, wdata, rdata, lfsr;
    logic [1:0] sysPllSrc, usbPllSrc, mainSrc;
    logic [3:0] sysPllGate, usbPllGate, mainGate;
    logic mainUsbRoute;
    logic [1:0] act [3];
    int fails, numChecks;

    css_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sysPllSrc(sysPllSrc), .sysPllGate(sysPllGate), .usbPllSrc(usbPllSrc),
        .usbPllGate(usbPllGate), .mainSrc(mainSrc), .mainGate(mainGate),
        .mainUsbRoute(mainUsbRoute));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
    endfunction

    function automatic logic [5:0] mux_out(int m);
        return (m == 0) ? {sysPllGate, sysPllSrc} : (m == 1) ? {usbPllGate, usbPllSrc}
            : {mainGate, mainSrc};
    endfunction

    function automatic logic [5:0] settled(logic [1:0] c);
        return {4'h1 << c, c};
    endfunction

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand for one cycle only, then the port returns to zero
    task automatic rd_chk(string nm, logic [31:0] a, logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(nm, e, rdata);
        @(negedge clk);
        `CHK("rdata idle", 32'h0, rdata);
    endtask

    task automatic hold_check(int m, int n);
        repeat (n) begin
            @(negedge clk);
            `CHK("mux held", settled(act[m]), mux_out(m));
        end
    endtask

    // Selector with random upper bits, then update zero and one
    task automatic handover(int m, logic [1:0] code);
        wr_reg(css_pkg::SEL_ADDR[m], {lfsr[31:2], code});
        lfsr = lfsr_next(lfsr);
        wr_reg(css_pkg::UPD_ADDR[m], {lfsr[31:1], 1'b0});
        wr_reg(css_pkg::UPD_ADDR[m], {lfsr[31:1], 1'b1});
        lfsr = lfsr_next(lfsr);
        if (code === act[m]) begin
            hold_check(m, 5);
        end else begin
            repeat (3) begin
                @(negedge clk);
                `CHK("gate gap", 4'h0, mux_out(m) >> 2);
            end
            act[m] = code;
            hold_check(m, 1);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        lfsr = 32'hB8AE_440A;
        act = '{2'h0, 2'h0, 2'h0};
        fails = 0;
        numChecks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            hold_check(m, 1);
            rd_chk("select reset", css_pkg::SEL_ADDR[m], 32'h0);
            rd_chk("update reset", css_pkg::UPD_ADDR[m], 32'h0);
        end
        rd_chk("route reset", css_pkg::USB_ROUTE_ENABLE_ADDR, 32'h0);
        rd_chk("unmapped", 32'h4004_8050, 32'h0);
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 7; k++)
                handover(m, (k < 4) ? 2'(k + 1) : (k == 4) ? act[m] : lfsr[1:0]);
            // Selector alone, then a one written over a one: no handover either way
            wr_reg(css_pkg::SEL_ADDR[m], {lfsr[31:2], ~act[m]});
            hold_check(m, 4);
            rd_chk("select masked", css_pkg::SEL_ADDR[m], {30'h0, ~act[m]});
            wr_reg(css_pkg::UPD_ADDR[m], 32'hFFFF_FFFF);
            hold_check(m, 5);
            rd_chk("update masked", css_pkg::UPD_ADDR[m], 32'h1);
            lfsr = lfsr_next(lfsr);
        end
        wr_reg(css_pkg::USB_ROUTE_ENABLE_ADDR, {lfsr[31:1], 1'b1});
        @(negedge clk);
        `CHK("usb route", 1'b1, mainUsbRoute);
        rd_chk("route read", css_pkg::USB_ROUTE_ENABLE_ADDR, 32'h1);
        rd_chk("status", css_pkg::MUX_STATUS_ADDR, {26'h0, act[2], act[1], act[0]});
        // Reset in mid-run returns every mux to the oscillator
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        act = '{2'h0, 2'h0, 2'h0};
        for (int m = 0; m < 3; m++)
            hold_check(m, 1);
        `CHK("route after reset", 1'b0, mainUsbRoute);
        handover(2, 2'h3);
        report_and_stop();
    end

    initial begin
        #(100 * 4000);
        fails++;
        report_and_stop();
    end
endmodule
